/* rtl/mbaf_defines.svh */
// constants of the mode based access firewall: maps, offsets, resets
// assumes a 16-bit physical memory map and an 8-bit register space
`ifndef MBAF_DEFINES_SVH
`define MBAF_DEFINES_SVH

// ----------------------------------------
// mode inputs
// ----------------------------------------
`define MBAF_MB_BOOT     1
`define MBAF_MB_TEST     0
`define MBAF_PSW_COS     6
`define MBAF_PSW_SYS     7

// ----------------------------------------
// physical memory partitions
// ----------------------------------------
`define MBAF_ROM_T_LO    16'h0000
`define MBAF_ROM_T_HI    16'h0FFF
`define MBAF_ROM_A_LO    16'h1000
`define MBAF_ROM_A_HI    16'h7FFF
`define MBAF_EE_R_LO     16'h8000
`define MBAF_EE_R_HI     16'h83FF
`define MBAF_EE_A_LO     16'h8400
`define MBAF_EE_A_HI     16'hBFFF
`define MBAF_RAM_R_LO    16'hC000
`define MBAF_RAM_R_HI    16'hC3FF
`define MBAF_RAM_A_LO    16'hC400
`define MBAF_RAM_A_HI    16'hFFFF
`define MBAF_ACM_LO      16'h7FC0
`define MBAF_ACM_HI      16'h7FFF
`define MBAF_SROW_LO     16'h8400
`define MBAF_SROW_HI     16'h840F
`define MBAF_COPRAM_LO   16'hF000
`define MBAF_COPRAM_HI   16'hFFFF

// ----------------------------------------
// register groups and own registers
// ----------------------------------------
`define MBAF_G_GEN       8'h80
`define MBAF_G_SYS       8'h90
`define MBAF_G_MMU       8'hA0
`define MBAF_G_FW        8'hA8
`define MBAF_G_COS       8'hB0
`define MBAF_G_TST       8'hB8
`define MBAF_G_HW        8'hC0
`define MBAF_R_MODE      8'h90
`define MBAF_R_SPTR_L    8'hA0
`define MBAF_R_SPTR_H    8'hA1
`define MBAF_R_SIDX      8'hA2
`define MBAF_R_SFLD      8'hA3
`define MBAF_R_SDATA     8'hA4
`define MBAF_R_FW_L      8'hA8
`define MBAF_R_FW_H      8'hA9
`define MBAF_R_XB_L      8'hAA
`define MBAF_R_XB_H      8'hAB
`define MBAF_R_XS_L      8'hAC
`define MBAF_R_XS_H      8'hAD
`define MBAF_SEG_BYTES   3'h7
`define MBAF_RST8        8'h00
`define MBAF_RST16       16'h0000

`endif

/* rtl/mbaf_firewall.sv */
// mode based access firewall: mode, segment translation, checks
// assumes all requests come from logic on mclk, one per cycle
`timescale 1ns/1ns
`include "mbaf_defines.svh"

// Contract
// - five cpu modes from status and bits
// - sixty-four segments with rights, bounds, offset
// - segments carry hardware register rights
// - segment without any right is disabled
// - virtual addresses mapped to physical
// - access performed only after check passes
// - every register access from 8'h90 up checked by mode
// - user uses segment, os uses firewall
// - denied read gives zero, write dropped
// - boot: test rom, reserved eeprom, ram
// - test mode: whole rom, eeprom, ram
// - os mode: test rom, reserved parts
// - system: application rom, eeprom, ram
// - user: segment table with class limits
// - os reads access condition table
// - os reaches exchange ram window
// - boot and os read security row
// - coprocessor reads eeprom, uses its ram
// - firewall registers: hw rights, window
// - segment table pointer register held
// - rom, eeprom, ram partitioned
// - segment config only in system mode
// - general cpu registers always open
module mbaf_firewall (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic [1:0]             mode_bits,
  input  wire logic [7:0]             program_status_high,
  input  wire logic [15:0]            cpu_pc,
  input  wire mbaf_pkg::mbaf_mem_req_t mem_req,
  output mbaf_pkg::mbaf_mem_acc_t     mem_acc,
  input  wire mbaf_pkg::mbaf_sfr_req_t sfr_req,
  input  wire logic [7:0]             sfr_ext_rdata,
  output mbaf_pkg::mbaf_sfr_req_t     sfr_fwd,
  output logic [7:0]                  sfr_rdata,
  input  wire mbaf_pkg::mbaf_cop_req_t cop_req,
  output mbaf_pkg::mbaf_cop_req_t     cop_acc,
  output mbaf_pkg::mbaf_mode_t        cpu_mode
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  mbaf_pkg::mbaf_seg_t  seg_tab [64]; // segment entries
  logic [15:0]          seg_ptr;      // table location
  logic [5:0]           seg_idx;      // entry selector
  logic [2:0]           seg_fld;      // byte selector
  logic [15:0]          fw_ctrl;      // os hw rights
  logic [15:0]          xw_base;      // exchange base
  logic [15:0]          xw_size;      // exchange size
  mbaf_pkg::mbaf_mode_t mode;         // current mode

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // lowest matching enabled entry wins
  function automatic logic [6:0] seg_find(input logic [15:0] a);
    logic [6:0] res;
    res = 7'h00;
    for (int i = 63; i >= 0; i--) begin
      // no right at all means disabled
      if ((|{seg_tab[i].sfr_w, seg_tab[i].sfr_r, seg_tab[i].x,
             seg_tab[i].w, seg_tab[i].r}) &&
          in_rng(a, seg_tab[i].first, seg_tab[i].last)) begin
        res = {1'b1, 6'(i)};
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // boot and test bits outrank the status word
  always_comb begin
    if (mode_bits[`MBAF_MB_BOOT]) begin
      mode = mbaf_pkg::mbaf_boot;
    end else if (mode_bits[`MBAF_MB_TEST]) begin
      mode = mbaf_pkg::mbaf_test;
    end else if (program_status_high[`MBAF_PSW_COS]) begin
      mode = mbaf_pkg::mbaf_cos;
    end else if (program_status_high[`MBAF_PSW_SYS]) begin
      mode = mbaf_pkg::mbaf_system;
    end else begin
      mode = mbaf_pkg::mbaf_user;
    end
  end

  // ----------------------------------------
  // memory translation and check
  // ----------------------------------------
  logic [6:0]          m_hit;   // segment for vaddr
  mbaf_pkg::mbaf_seg_t m_seg;   // its entry
  logic [15:0]         m_pa;    // physical address
  logic                m_ok;    // access allowed
  logic                is_r;
  logic                is_w;
  logic                is_x;
  logic                rom_t;
  logic                rom_a;
  logic                ee_r;
  logic                ee_a;
  logic                ram_r;
  logic                ram_a;
  logic                xwin;    // in exchange window
  logic [16:0]         xw_end;  // window end, exclusive

  // user mode relocates, other modes see flat memory
  always_comb begin
    m_hit = seg_find(mem_req.vaddr);
    m_seg = seg_tab[m_hit[5:0]];
    if (mode == mbaf_pkg::mbaf_user && m_hit[6]) begin
      m_pa = 16'(mem_req.vaddr + m_seg.offset);
    end else begin
      m_pa = mem_req.vaddr;
    end
  end

  // partition classes of the physical address
  always_comb begin
    is_r   = (mem_req.op == mbaf_pkg::mbaf_rd);
    is_w   = (mem_req.op == mbaf_pkg::mbaf_wr);
    is_x   = (mem_req.op == mbaf_pkg::mbaf_ex);
    rom_t  = in_rng(m_pa, `MBAF_ROM_T_LO, `MBAF_ROM_T_HI);
    rom_a  = in_rng(m_pa, `MBAF_ROM_A_LO, `MBAF_ROM_A_HI);
    ee_r   = in_rng(m_pa, `MBAF_EE_R_LO, `MBAF_EE_R_HI);
    ee_a   = in_rng(m_pa, `MBAF_EE_A_LO, `MBAF_EE_A_HI);
    ram_r  = in_rng(m_pa, `MBAF_RAM_R_LO, `MBAF_RAM_R_HI);
    ram_a  = in_rng(m_pa, `MBAF_RAM_A_LO, `MBAF_RAM_A_HI);
    xw_end = {1'b0, xw_base} + {1'b0, xw_size};
    xwin   = ram_a && (m_pa >= xw_base) && ({1'b0, m_pa} < xw_end);
  end

  // rights per mode; rom never written, ram never executed
  always_comb begin
    m_ok = 1'b0; // closed unless a mode arm opens it
    unique case (mode)
      mbaf_pkg::mbaf_boot: begin
        m_ok = (rom_t && !is_w) || ee_r || (ram_r && !is_x) ||
               (is_r && in_rng(m_pa, `MBAF_SROW_LO,
                               `MBAF_SROW_HI));
      end
      mbaf_pkg::mbaf_test: begin
        m_ok = ((rom_t || rom_a) && !is_w) || ee_r || ee_a ||
               ((ram_r || ram_a) && !is_x);
      end
      mbaf_pkg::mbaf_cos: begin
        m_ok = (rom_t && !is_w) || ee_r || (ram_r && !is_x) ||
               (is_r && in_rng(m_pa, `MBAF_ACM_LO,
                               `MBAF_ACM_HI)) ||
               (xwin && !is_x) ||
               (is_r && in_rng(m_pa, `MBAF_SROW_LO,
                               `MBAF_SROW_HI));
      end
      mbaf_pkg::mbaf_system: begin
        m_ok = (rom_a && !is_w) || ee_a ||
               (ram_a && !is_x);
      end
      mbaf_pkg::mbaf_user: begin
        // segment right and class limit both needed
        m_ok = m_hit[6] &&
               ((is_r && m_seg.r) || (is_w && m_seg.w) ||
                (is_x && m_seg.x)) &&
               ((rom_a && !is_w) || ee_a || (ram_a && !is_x));
      end
    endcase
  end

  // forwarded access: only a passed check drives en
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem_acc <= '0;
    end else begin
      mem_acc.en    <= mem_req.valid && m_ok;
      mem_acc.op    <= mem_req.op;
      mem_acc.paddr <= m_pa;
    end
  end

  // ----------------------------------------
  // register access check
  // ----------------------------------------
  logic [6:0] pc_hit;  // segment of executing code
  logic       g_gen;
  logic       g_sys;
  logic       g_mmu;
  logic       g_fw;
  logic       g_cos;
  logic       g_tst;
  logic       g_hw;
  logic       own;     // register kept in this block
  logic       ok_r;    // read allowed
  logic       ok_w;    // write allowed
  logic       fw_bit;  // os right for hw subgroup
  logic       pw;      // boot, test or system
  logic [7:0] own_rd;  // own register read value
  logic [7:0] sa;

  always_comb begin
    sa     = sfr_req.addr;
    pc_hit = seg_find(cpu_pc);
    g_gen  = (sa >= `MBAF_G_GEN) && (sa < `MBAF_G_SYS);
    g_sys  = (sa >= `MBAF_G_SYS) && (sa < `MBAF_G_MMU);
    g_mmu  = (sa >= `MBAF_G_MMU) && (sa < `MBAF_G_FW);
    g_fw   = (sa >= `MBAF_G_FW) && (sa < `MBAF_G_COS);
    g_cos  = (sa >= `MBAF_G_COS) && (sa < `MBAF_G_TST);
    g_tst  = (sa >= `MBAF_G_TST) && (sa < `MBAF_G_HW);
    g_hw   = (sa >= `MBAF_G_HW);
    own    = (sa == `MBAF_R_MODE) ||
             (g_mmu && sa <= `MBAF_R_SDATA) ||
             (g_fw && sa <= `MBAF_R_XS_H);
    fw_bit = fw_ctrl[sa[5:2]];
    pw     = (mode == mbaf_pkg::mbaf_boot) ||
             (mode == mbaf_pkg::mbaf_test) ||
             (mode == mbaf_pkg::mbaf_system);
  end

  // mode decides each group but the general one; below 8'h80 nothing answers
  always_comb begin
    ok_r = 1'b0;
    ok_w = 1'b0;
    if (g_gen) begin
      ok_r = 1'b1;
      ok_w = 1'b1;
    end else if (g_sys) begin
      ok_r = pw;
      ok_w = pw;
    end else if (g_mmu) begin
      ok_r = (mode == mbaf_pkg::mbaf_system);
      ok_w = (mode == mbaf_pkg::mbaf_system);
    end else if (g_fw) begin
      ok_r = pw || (mode == mbaf_pkg::mbaf_cos);
      ok_w = pw;
    end else if (g_cos) begin
      ok_r = pw && (mode != mbaf_pkg::mbaf_system) ||
             (mode == mbaf_pkg::mbaf_cos);
      ok_w = ok_r;
    end else if (g_tst) begin
      ok_r = (mode == mbaf_pkg::mbaf_boot) ||
             (mode == mbaf_pkg::mbaf_test);
      ok_w = ok_r;
    end else if (g_hw) begin
      // user by executing segment, os by firewall
      if (mode == mbaf_pkg::mbaf_user) begin
        ok_r = pc_hit[6] && seg_tab[pc_hit[5:0]].sfr_r;
        ok_w = pc_hit[6] && seg_tab[pc_hit[5:0]].sfr_w;
      end else if (mode == mbaf_pkg::mbaf_cos) begin
        ok_r = fw_bit;
        ok_w = fw_bit;
      end else begin
        ok_r = 1'b1;
        ok_w = 1'b1;
      end
    end
  end

  // own register read mux
  always_comb begin
    own_rd = 8'h00;
    unique case (sa)
      `MBAF_R_MODE:   own_rd = {5'h00, mode};
      `MBAF_R_SPTR_L: own_rd = seg_ptr[7:0];
      `MBAF_R_SPTR_H: own_rd = seg_ptr[15:8];
      `MBAF_R_SIDX:   own_rd = {2'h0, seg_idx};
      `MBAF_R_SFLD:   own_rd = {5'h00, seg_fld};
      `MBAF_R_SDATA: begin
        if (seg_fld < `MBAF_SEG_BYTES) begin
          own_rd = seg_tab[seg_idx][{seg_fld, 3'h0} +: 8];
        end
      end
      `MBAF_R_FW_L:   own_rd = fw_ctrl[7:0];
      `MBAF_R_FW_H:   own_rd = fw_ctrl[15:8];
      `MBAF_R_XB_L:   own_rd = xw_base[7:0];
      `MBAF_R_XB_H:   own_rd = xw_base[15:8];
      `MBAF_R_XS_L:   own_rd = xw_size[7:0];
      `MBAF_R_XS_H:   own_rd = xw_size[15:8];
      default:        own_rd = 8'h00;
    endcase
  end

  logic wr_ok; // write that passed the check
  assign wr_ok = sfr_req.wr && ok_w;

  // read data one cycle on; denied gives zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= `MBAF_RST8;
    end else if (sfr_req.rd && ok_r) begin
      sfr_rdata <= own ? own_rd : sfr_ext_rdata;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // forwarding to outside registers only when granted
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfr_fwd <= '0;
    end else begin
      sfr_fwd.rd    <= sfr_req.rd && ok_r && !own;
      sfr_fwd.wr    <= wr_ok && !own; // dropped if denied
      sfr_fwd.addr  <= sa;
      sfr_fwd.wdata <= sfr_req.wdata;
    end
  end

  // ----------------------------------------
  // segmentation configuration
  // ----------------------------------------
  // pointer and selectors, system mode only via ok_w
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seg_ptr <= `MBAF_RST16;
      seg_idx <= 6'h00;
      seg_fld <= 3'h0;
    end else if (wr_ok) begin
      unique case (sa)
        `MBAF_R_SPTR_L: seg_ptr[7:0]  <= sfr_req.wdata;
        `MBAF_R_SPTR_H: seg_ptr[15:8] <= sfr_req.wdata;
        `MBAF_R_SIDX:   seg_idx <= sfr_req.wdata[5:0];
        `MBAF_R_SFLD:   seg_fld <= sfr_req.wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // entry byte writes; a reset table grants nothing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 64; i++) begin
        seg_tab[i] <= '0;
      end
    end else if (wr_ok && sa == `MBAF_R_SDATA &&
                 seg_fld < `MBAF_SEG_BYTES) begin
      seg_tab[seg_idx][{seg_fld, 3'h0} +: 8] <= sfr_req.wdata;
    end
  end

  // ----------------------------------------
  // firewall and exchange window
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fw_ctrl <= `MBAF_RST16;
      xw_base <= `MBAF_RST16;
      xw_size <= `MBAF_RST16;
    end else if (wr_ok) begin
      unique case (sa)
        `MBAF_R_FW_L: fw_ctrl[7:0]  <= sfr_req.wdata;
        `MBAF_R_FW_H: fw_ctrl[15:8] <= sfr_req.wdata;
        `MBAF_R_XB_L: xw_base[7:0]  <= sfr_req.wdata;
        `MBAF_R_XB_H: xw_base[15:8] <= sfr_req.wdata;
        `MBAF_R_XS_L: xw_size[7:0]  <= sfr_req.wdata;
        `MBAF_R_XS_H: xw_size[15:8] <= sfr_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // coprocessor path and mode output
  // ----------------------------------------
  logic c_ok; // coprocessor access allowed
  always_comb begin
    c_ok = (!cop_req.wr &&
            in_rng(cop_req.addr, `MBAF_EE_R_LO, `MBAF_EE_A_HI)) ||
           in_rng(cop_req.addr, `MBAF_COPRAM_LO,
                  `MBAF_COPRAM_HI);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cop_acc  <= '0;
      cpu_mode <= mbaf_pkg::mbaf_boot;
    end else begin
      cop_acc.valid <= cop_req.valid && c_ok;
      cop_acc.wr    <= cop_req.wr;
      cop_acc.addr  <= cop_req.addr;
      cpu_mode      <= mode;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_deny_zero;
    @(posedge mclk) disable iff (!rstn)
    sfr_req.rd && !ok_r |=> sfr_rdata == 8'h00;
  endproperty
  a_deny_zero: assert property (p_deny_zero)
    else $error("denied read not zero");

  property p_mmu_locked;
    @(posedge mclk) disable iff (!rstn)
    sfr_req.wr && g_mmu && mode != mbaf_pkg::mbaf_system
    |=> $stable(seg_ptr) && $stable(seg_idx);
  endproperty
  a_mmu_locked: assert property (p_mmu_locked)
    else $error("segment config changed outside system");

  property p_gen_open;
    @(posedge mclk) disable iff (!rstn)
    sfr_req.rd && g_gen |=> sfr_fwd.rd;
  endproperty
  a_gen_open: assert property (p_gen_open)
    else $error("general register read blocked");

  property p_no_deny_fwd;
    @(posedge mclk) disable iff (!rstn)
    mem_req.valid && !m_ok |=> !mem_acc.en;
  endproperty
  a_no_deny_fwd: assert property (p_no_deny_fwd)
    else $error("denied access reached memory");

  property p_test_rom;
    @(posedge mclk) disable iff (!rstn)
    mem_req.valid && mode == mbaf_pkg::mbaf_test &&
    mem_req.op == mbaf_pkg::mbaf_rd && mem_req.vaddr < 16'h8000
    |=> mem_acc.en && mem_acc.paddr == $past(mem_req.vaddr);
  endproperty
  a_test_rom: assert property (p_test_rom)
    else $error("test mode rom read refused");

  property p_user_rom_wr;
    @(posedge mclk) disable iff (!rstn)
    mem_req.valid && mode == mbaf_pkg::mbaf_user &&
    mem_req.op == mbaf_pkg::mbaf_wr && m_pa <= `MBAF_ROM_A_HI
    |=> !mem_acc.en;
  endproperty
  a_user_rom_wr: assert property (p_user_rom_wr)
    else $error("user rom write granted");

  property p_cop_wr;
    @(posedge mclk) disable iff (!rstn)
    cop_req.valid && cop_req.wr && cop_req.addr[15:14] == 2'h2
    |=> !cop_acc.valid;
  endproperty
  a_cop_wr: assert property (p_cop_wr)
    else $error("coprocessor eeprom write granted");

  property p_sys_ee;
    @(posedge mclk) disable iff (!rstn)
    mem_req.valid && mode == mbaf_pkg::mbaf_system &&
    mem_req.vaddr >= `MBAF_EE_A_LO && mem_req.vaddr <= `MBAF_EE_A_HI
    |=> mem_acc.en && mem_acc.paddr == $past(mem_req.vaddr);
  endproperty
  a_sys_ee: assert property (p_sys_ee)
    else $error("system eeprom access refused");

  property p_user_hw;
    @(posedge mclk) disable iff (!rstn)
    sfr_req.wr && g_hw && mode == mbaf_pkg::mbaf_user && !pc_hit[6]
    |=> !sfr_fwd.wr;
  endproperty
  a_user_hw: assert property (p_user_hw)
    else $error("user hw write without segment");

endmodule

/* rtl/mbaf_pkg.sv */
// types of the mode based access firewall
// assumes mbaf_defines.svh for all numbers
package mbaf_pkg;

  // ----------------------------------------
  // cpu modes and memory operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    mbaf_boot, mbaf_test, mbaf_cos, mbaf_system, mbaf_user
  } mbaf_mode_t;

  typedef enum logic [1:0] {
    mbaf_rd, mbaf_wr, mbaf_ex
  } mbaf_op_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid; // request this cycle
    mbaf_op_t    op;    // read, write, execute
    logic [15:0] vaddr; // virtual address
  } mbaf_mem_req_t;

  typedef struct packed {
    logic        en;    // granted access
    mbaf_op_t    op;
    logic [15:0] paddr; // physical address
  } mbaf_mem_acc_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } mbaf_sfr_req_t;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [15:0] addr;
  } mbaf_cop_req_t;

  // one segment entry, seven bytes, flags in byte 0
  typedef struct packed {
    logic [15:0] offset; // relocation
    logic [15:0] last;   // last valid virtual address
    logic [15:0] first;  // first valid virtual address
    logic [2:0]  pad;
    logic        sfr_w;  // hardware register write
    logic        sfr_r;  // hardware register read
    logic        x;
    logic        w;
    logic        r;
  } mbaf_seg_t;

endpackage

/* sim/mbaf_ext_regs.sv */
// outside register model standing behind the firewall's register port
// assumes the read value is needed in the request cycle
`timescale 1ns/1ns

module mbaf_ext_regs (
  input  wire logic [7:0] addr,
  output logic [7:0]      rdata
);
  // nibble swap: each address gives its own value, all zero only for address 8'h00
  assign rdata = {addr[3:0], addr[7:4]};
endmodule

/* sim/test_mbaf_firewall.sv */
// self-checking bench of the mode based access firewall
// assumes one clock, a combinational outside register model
`timescale 1ns/1ns
`include "mbaf_defines.svh"

module test_mbaf_firewall;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic                    mclk      = 1'b0;
  logic                    rstn      = 1'b0;
  logic [1:0]              mode_bits = 2'h2;   // boot during reset
  logic [7:0]              psw       = 8'h00;
  logic [15:0]             cpu_pc    = 16'h0000;
  mbaf_pkg::mbaf_mem_req_t mem_req   = '0;
  mbaf_pkg::mbaf_sfr_req_t sfr_req   = '0;
  mbaf_pkg::mbaf_cop_req_t cop_req   = '0;
  mbaf_pkg::mbaf_mem_acc_t mem_acc;
  mbaf_pkg::mbaf_sfr_req_t sfr_fwd;
  mbaf_pkg::mbaf_cop_req_t cop_acc;
  mbaf_pkg::mbaf_mode_t    cpu_mode;
  logic [7:0]              ext_rdata;
  logic [7:0]              sfr_rdata;
  int                      errors    = 0;
  int                      cmp_count = 0;

  always #10 mclk = ~mclk;

  mbaf_firewall i_mbaf_firewall (.mclk(mclk), .rstn(rstn),
    .mode_bits(mode_bits), .program_status_high(psw), .cpu_pc(cpu_pc),
    .mem_req(mem_req), .mem_acc(mem_acc), .sfr_req(sfr_req),
    .sfr_ext_rdata(ext_rdata), .sfr_fwd(sfr_fwd), .sfr_rdata(sfr_rdata),
    .cop_req(cop_req), .cop_acc(cop_acc), .cpu_mode(cpu_mode));

  mbaf_ext_regs i_mbaf_ext_regs (.addr(sfr_req.addr), .rdata(ext_rdata));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // mode inputs change, then two edges so the registered mode settles
  task automatic set_mode(input logic [1:0] mb, input logic [7:0] p,
                          input logic [2:0] em);
    @(posedge mclk);
    mode_bits <= mb;
    psw <= p;
    repeat (2) @(posedge mclk);
    #1;
    chk("cpu_mode", {13'h0, cpu_mode}, {13'h0, em});
  endtask

  // one memory request; paddr only matters when granted
  task automatic mem(input logic [1:0] op, input logic [15:0] va,
                     input logic en, input logic [15:0] pa);
    @(posedge mclk);
    mem_req <= '{1'b1, mbaf_pkg::mbaf_op_t'(op), va};
    @(posedge mclk);
    mem_req.valid <= 1'b0;
    #1;
    chk("mem_en", {15'h0, mem_acc.en}, {15'h0, en});
    if (en) chk("mem_paddr", mem_acc.paddr, pa);
    if (en) chk("mem_op", {14'h0, mem_acc.op}, {14'h0, op});
  endtask

  // one register strobe; ed is read data, ef whether it is forwarded
  task automatic sfr(input logic wr, input logic [7:0] a, d, ed,
                     input logic ef);
    @(posedge mclk);
    sfr_req <= '{~wr, wr, a, d};
    @(posedge mclk);
    sfr_req <= '0;
    #1;
    if (!wr) chk("sfr_rdata", {8'h00, sfr_rdata}, {8'h00, ed});
    chk("sfr_fwd", {14'h0, sfr_fwd.rd, sfr_fwd.wr},
        {14'h0, ~wr & ef, wr & ef});
    if (ef) chk("fwd_ad", {sfr_fwd.addr, sfr_fwd.wdata}, {a, d});
  endtask

  // entry n written byte by byte through index, select and data
  task automatic seg(input logic [7:0] n, input logic [55:0] e);
    sfr(1'b1, `MBAF_R_SIDX, n, 8'h00, 1'b0);
    for (int k = 0; k < 7; k++) begin
      sfr(1'b1, `MBAF_R_SFLD, 8'(k), 8'h00, 1'b0);
      sfr(1'b1, `MBAF_R_SDATA, e[8*k +: 8], 8'h00, 1'b0);
    end
  endtask

  task automatic cop(input logic wr, input logic [15:0] a, input logic ok);
    @(posedge mclk);
    cop_req <= '{1'b1, wr, a};
    @(posedge mclk);
    cop_req.valid <= 1'b0;
    #1;
    chk("cop_valid", {15'h0, cop_acc.valid}, {15'h0, ok});
    if (ok) chk("cop_addr", cop_acc.addr, a);
    if (ok) chk("cop_wr", {15'h0, cop_acc.wr}, {15'h0, wr});
  endtask

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    set_mode(2'h2, 8'h00, 3'h0);
    mem(2'h0, 16'h0000, 1'b1, 16'h0000);
    mem(2'h1, 16'h0000, 1'b0, 16'h0000);
    mem(2'h0, 16'h1000, 1'b0, 16'h0000);
    mem(2'h2, 16'h83FF, 1'b1, 16'h83FF);
    mem(2'h2, 16'hC000, 1'b0, 16'h0000);
    mem(2'h0, 16'h840F, 1'b1, 16'h840F);
    mem(2'h0, 16'h8410, 1'b0, 16'h0000);
    cop(1'b0, 16'h8000, 1'b1);
    cop(1'b1, 16'h8000, 1'b0);
    cop(1'b1, 16'hF000, 1'b1);
    cop(1'b0, 16'h1000, 1'b0);
    set_mode(2'h1, 8'h00, 3'h1);
    mem(2'h0, 16'h7FFF, 1'b1, 16'h7FFF);
    mem(2'h1, 16'hBFFF, 1'b1, 16'hBFFF);
    mem(2'h2, 16'hFFFF, 1'b0, 16'h0000);
    set_mode(2'h0, 8'h80, 3'h3);
    mem(2'h2, 16'h1000, 1'b1, 16'h1000);
    mem(2'h0, 16'h0FFF, 1'b0, 16'h0000);
    mem(2'h1, 16'h8000, 1'b0, 16'h0000);
    mem(2'h1, 16'hC400, 1'b1, 16'hC400);
    mem(2'h1, 16'h8400, 1'b1, 16'h8400);
    sfr(1'b1, 8'hC4, 8'h5A, 8'h00, 1'b1);
    sfr(1'b1, `MBAF_R_SPTR_L, 8'h34, 8'h00, 1'b0);
    sfr(1'b0, `MBAF_R_SPTR_L, 8'h00, 8'h34, 1'b0);
    sfr(1'b0, 8'h70, 8'h00, 8'h00, 1'b0);
    sfr(1'b0, 8'hC4, 8'h00, 8'h4C, 1'b1);
    sfr(1'b1, `MBAF_R_FW_L, 8'h02, 8'h00, 1'b0);
    sfr(1'b1, `MBAF_R_XB_H, 8'hC8, 8'h00, 1'b0);
    sfr(1'b1, `MBAF_R_XS_L, 8'h10, 8'h00, 1'b0);
    seg(8'h00, {16'h8300, 16'h01FF, 16'h0100, 8'h0D});
    seg(8'h01, {16'h0000, 16'h02FF, 16'h0200, 8'h00});
    seg(8'h02, {16'hC500, 16'h03FF, 16'h0300, 8'h07});
    set_mode(2'h0, 8'h40, 3'h2);
    mem(2'h0, 16'h7FC0, 1'b1, 16'h7FC0);
    mem(2'h0, 16'h7FBF, 1'b0, 16'h0000);
    mem(2'h1, 16'hC000, 1'b1, 16'hC000);
    mem(2'h0, 16'hC80F, 1'b1, 16'hC80F);
    mem(2'h0, 16'hC810, 1'b0, 16'h0000);
    sfr(1'b0, 8'hC4, 8'h00, 8'h4C, 1'b1);
    sfr(1'b0, 8'hC8, 8'h00, 8'h00, 1'b0);
    sfr(1'b1, `MBAF_R_FW_L, 8'hFF, 8'h00, 1'b0);
    sfr(1'b0, `MBAF_R_FW_L, 8'h00, 8'h02, 1'b0);
    @(posedge mclk) cpu_pc <= 16'h0150;
    set_mode(2'h0, 8'h00, 3'h4);
    mem(2'h0, 16'h0150, 1'b1, 16'h8450);
    mem(2'h1, 16'h01FF, 1'b0, 16'h0000);
    mem(2'h2, 16'h01FF, 1'b1, 16'h84FF);
    mem(2'h0, 16'h00FF, 1'b0, 16'h0000);
    mem(2'h0, 16'h0250, 1'b0, 16'h0000);
    mem(2'h1, 16'h0310, 1'b1, 16'hC810);
    mem(2'h2, 16'h0310, 1'b0, 16'h0000);
    mem(2'h1, 16'h00FF, 1'b0, 16'h0000);
    sfr(1'b0, 8'hC4, 8'h00, 8'h4C, 1'b1);
    sfr(1'b1, 8'hC4, 8'h55, 8'h00, 1'b0);
    sfr(1'b0, `MBAF_R_SPTR_L, 8'h00, 8'h00, 1'b0);
    sfr(1'b1, `MBAF_R_SPTR_L, 8'h99, 8'h00, 1'b0);
    sfr(1'b0, 8'h80, 8'h00, 8'h08, 1'b1);
    @(posedge mclk) cpu_pc <= 16'h0250;
    sfr(1'b0, 8'hC4, 8'h00, 8'h00, 1'b0);
    sfr(1'b1, 8'hC4, 8'h55, 8'h00, 1'b0);
    wrap_up;
  end

  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    #200000;
    errors++;
    wrap_up;
  end
endmodule
